// *** verilog/pfa_flag_aggregator.sv ***
// protection flag aggregator: alert and fault flags, FET gating, APB
// assumes violation inputs come from same-clock comparator and firmware
// logic; the two host FET-off pins arrive asynchronously
//
// What this block does
// [RULE1] autonomous bit set: autonomous; cleared: FET test
// [RULE2] host-forced FET off held until host releases
// [RULE3] evaluate only protections whose enable bit set
// [RULE4] group A by comparators, B and C firmware
// [RULE5] fault turns charge FET off if masked
// [RULE6] fault turns discharge FET off if masked
// [RULE7] charge-off protections also cut precharge FET
// [RULE8] discharge-off protections also cut predischarge FET
// [RULE9] alert set in the same evaluation as violation
// [RULE10] three alert words; any alert drives interrupt
// [RULE11] fault only after violation persists full delay
// [RULE12] three fault words; any fault drives interrupt
// [RULE13] group A bit layout, bits one, zero reserved
// [RULE14] group B bit layout, bit three reserved
// [RULE15] group C alert layout with timer-paused bit
// [RULE16] group C fault layout with timeout bits
// [RULE17] timer-paused alert while precharge timer suspended
// [RULE18] release command only when nothing blocks
// [RULE19] reserved bits read zero, ignore writes
// [RULE20] alert clears itself once violation goes away
`timescale 1ns/1ps
module pfa_flag_aggregator
  import pfa_pkg::*;
#(
  parameter int DLY_W = 16
) (
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // protection sources
  input  wire logic [FLAG_W-1:0] prot_violation,
  input  wire logic              fw_eval_tick,
  input  wire logic              precharge_timer_paused,
  input  wire logic              pchg_request,
  input  wire logic              pdsg_request,
  // host pins
  input  wire logic              charge_path_off_pin,
  input  wire logic              discharge_path_off_pin,
  output logic                   host_alert,
  // switch drive
  output pfa_fet_s               autonomous_switch_ctrl
);

  logic [1:0]        pin_s1_r;
  logic [1:0]        pin_s2_r;
  logic [1:0]        pin_s3_r;
  logic [1:0]        pin_lvl_r;
  logic [1:0]        pin_agree;
  logic [FLAG_W-1:0] prot_en_r;
  logic [FLAG_W-1:0] chg_mask_r;
  logic [FLAG_W-1:0] dsg_mask_r;
  logic [DLY_W-1:0]  dly_r [NGRP];
  logic              autonomous_switch_ctrl_r;
  logic [FET_W-1:0]  test_r;
  logic              hold_chg_r;
  logic              hold_dsg_r;
  logic [FLAG_W-1:0] viol_hold_r;
  logic [FLAG_W-1:0] eval_mask;
  logic [FLAG_W-1:0] viol_eff;
  logic [FLAG_W-1:0] active;
  logic [FLAG_W-1:0] due;
  logic [FLAG_W-1:0] alert_r;
  logic [FLAG_W-1:0] alert_nxt;
  logic [FLAG_W-1:0] fault_r;
  logic [FLAG_W-1:0] fault_nxt;
  logic              chg_block;
  logic              dsg_block;
  logic              wr_en;
  logic              release_all_switches_cmd;
  logic              map_hit;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] prdata_r;
  pfa_fet_s          fet_r;
  pfa_fet_s          fet_nxt;
  logic              host_alert_r;

  assign prdata     = prdata_r;
  assign autonomous_switch_ctrl     = fet_r;
  assign host_alert = host_alert_r;

  // host pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else if (clk_en) begin
      pin_s1_r <= {discharge_path_off_pin, charge_path_off_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_agree = ~(pin_s2_r ^ pin_s3_r);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_lvl_r <= '0;
    end else if (clk_en) begin
      pin_lvl_r <= (pin_agree & pin_s2_r) | (~pin_agree & pin_lvl_r);
    end
  end

  // apb: no wait states while enabled, a frozen block stalls the bus
  assign pready  = clk_en;
  assign wr_en   = psel & penable & pwrite & clk_en;
  assign map_hit = (paddr[1:0] == 2'b00) &&
                   (paddr[ADDR_W-1:2] >= IDX_CMP_ALERT) &&
                   (paddr[ADDR_W-1:2] <= IDX_STATUS);
  assign pslverr = psel & penable & ~map_hit;
  assign release_all_switches_cmd = wr_en & pfa_hit(paddr, IDX_CTRL) &
                                    pwdata[CTRL_RELEASE_BIT];

  // flag words accept no writes, so reserved bits cannot be set
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prot_en_r  <= FLAG_RST;
      chg_mask_r <= FLAG_RST;
      dsg_mask_r <= FLAG_RST;
      autonomous_switch_ctrl_r <= CTRL_AUTO_RST;
      test_r     <= '0;
    end else if (wr_en) begin
      if (pfa_hit(paddr, IDX_PROT_EN)) begin
        prot_en_r <= pwdata[FLAG_W-1:0];
      end
      if (pfa_hit(paddr, IDX_CHG_MASK)) begin
        chg_mask_r <= pwdata[FLAG_W-1:0];
      end
      if (pfa_hit(paddr, IDX_DSG_MASK)) begin
        dsg_mask_r <= pwdata[FLAG_W-1:0];
      end
      if (pfa_hit(paddr, IDX_CTRL)) begin
        autonomous_switch_ctrl_r <= pwdata[CTRL_AUTO_BIT];
        test_r <= pwdata[CTRL_TEST_LSB +: FET_W];
      end
    end
  end

  // one delay register per group, counted in evaluations
  generate
    for (genvar g = 0; g < NGRP; g++) begin : g_dly
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          dly_r[g] <= '0;
        end else if (wr_en &&
                     pfa_hit(paddr, IDX_DLY_A + IDX_W'(g))) begin
          dly_r[g] <= pwdata[DLY_W-1:0];
        end
      end
    end
  endgenerate

  // read data is captured in the setup phase, valid through access
  always_comb begin
    rd_mux = '0;
    if (pfa_hit(paddr, IDX_CMP_ALERT)) begin
      rd_mux[GRP_W-1:0] = alert_r[GRP_A_LSB +: GRP_W]; // RULE13
    end else if (pfa_hit(paddr, IDX_CMP_FAULT)) begin
      rd_mux[GRP_W-1:0] = fault_r[GRP_A_LSB +: GRP_W]; // RULE12
    end else if (pfa_hit(paddr, IDX_THM_ALERT)) begin
      rd_mux[GRP_W-1:0] = alert_r[GRP_B_LSB +: GRP_W]; // RULE14
    end else if (pfa_hit(paddr, IDX_THM_FAULT)) begin
      rd_mux[GRP_W-1:0] = fault_r[GRP_B_LSB +: GRP_W]; // RULE14
    end else if (pfa_hit(paddr, IDX_MISC_ALERT)) begin
      rd_mux[GRP_W-1:0] = alert_r[GRP_C_LSB +: GRP_W]; // RULE15
    end else if (pfa_hit(paddr, IDX_MISC_FAULT)) begin
      rd_mux[GRP_W-1:0] = fault_r[GRP_C_LSB +: GRP_W]; // RULE16
    end else if (pfa_hit(paddr, IDX_PROT_EN)) begin
      rd_mux[FLAG_W-1:0] = prot_en_r;
    end else if (pfa_hit(paddr, IDX_CHG_MASK)) begin
      rd_mux[FLAG_W-1:0] = chg_mask_r;
    end else if (pfa_hit(paddr, IDX_DSG_MASK)) begin
      rd_mux[FLAG_W-1:0] = dsg_mask_r;
    end else if (pfa_hit(paddr, IDX_DLY_A)) begin
      rd_mux[DLY_W-1:0] = dly_r[0];
    end else if (pfa_hit(paddr, IDX_DLY_A + IDX_W'(1))) begin
      rd_mux[DLY_W-1:0] = dly_r[1];
    end else if (pfa_hit(paddr, IDX_DLY_C)) begin
      rd_mux[DLY_W-1:0] = dly_r[2];
    end else if (pfa_hit(paddr, IDX_CTRL)) begin
      rd_mux[CTRL_AUTO_BIT]    = autonomous_switch_ctrl_r;
      rd_mux[CTRL_CHG_OFF_BIT] = hold_chg_r;
      rd_mux[CTRL_DSG_OFF_BIT] = hold_dsg_r;
      rd_mux[CTRL_TEST_LSB +: FET_W] = test_r;
    end else if (pfa_hit(paddr, IDX_STATUS)) begin
      rd_mux[FET_W-1:0]       = fet_r;
      rd_mux[FET_W +: 2]      = pin_lvl_r;
      rd_mux[FET_W + 2 +: 2]  = {hold_dsg_r, hold_chg_r};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= '0;
    end else if (clk_en && psel && !penable) begin
      prdata_r <= rd_mux;
    end
  end

  // comparators report every cycle, firmware results only on its tick
  assign eval_mask = HW_GROUP | (fw_eval_tick ? ~HW_GROUP : FLAG_RST); // RULE4
  assign viol_eff  = (prot_violation & eval_mask) |
                     (viol_hold_r & ~eval_mask);
  assign active    = prot_en_r & viol_eff; // RULE3

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      viol_hold_r <= FLAG_RST;
    end else if (clk_en) begin
      viol_hold_r <= viol_eff;
    end
  end

  // persistence counters; any break in the violation restarts the count
  generate
    for (genvar i = 0; i < FLAG_W; i++) begin : g_cnt
      localparam int G = (FLAG_W - 1 - i) / GRP_W;
      logic [DLY_W-1:0] cnt_r;
      assign due[i] = (cnt_r >= dly_r[G]);
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          cnt_r <= '0;
        end else if (clk_en) begin
          if (!active[i]) begin
            cnt_r <= '0;
          end else if (eval_mask[i] && !due[i]) begin
            cnt_r <= cnt_r + 1'b1; // RULE11
          end
        end
      end
    end
  endgenerate

  assign fault_nxt = active & (fault_r | due) & FAULT_VALID; // RULE11 RULE19
  assign alert_nxt = (active & ALERT_VALID & ~PRECHARGE_TIMER_PAUSED_FLAG_FLAG) | // RULE9 RULE20
                     (precharge_timer_paused ? PRECHARGE_TIMER_PAUSED_FLAG_FLAG : FLAG_RST); // RULE17

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_r      <= FLAG_RST;
      fault_r      <= FLAG_RST;
      host_alert_r <= 1'b0;
    end else if (clk_en) begin
      alert_r      <= alert_nxt;
      fault_r      <= fault_nxt;
      host_alert_r <= (|alert_nxt) | (|fault_nxt); // RULE10 RULE12
    end
  end

  assign chg_block = |(fault_r & chg_mask_r); // RULE5
  assign dsg_block = |(fault_r & dsg_mask_r); // RULE6

  // a pin or host command sets the hold; set beats a same-cycle release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_chg_r <= 1'b0;
      hold_dsg_r <= 1'b0;
    end else if (clk_en) begin
      if (pin_lvl_r[0] || (wr_en && pfa_hit(paddr, IDX_CTRL) &&
                           pwdata[CTRL_CHG_OFF_BIT])) begin
        hold_chg_r <= 1'b1; // RULE2
      end else if (release_all_switches_cmd && !chg_block) begin
        hold_chg_r <= 1'b0; // RULE18
      end
      if (pin_lvl_r[1] || (wr_en && pfa_hit(paddr, IDX_CTRL) &&
                           pwdata[CTRL_DSG_OFF_BIT])) begin
        hold_dsg_r <= 1'b1; // RULE2
      end else if (release_all_switches_cmd && !dsg_block) begin
        hold_dsg_r <= 1'b0; // RULE18
      end
    end
  end

  // test mode drives each switch straight from software
  always_comb begin
    if (autonomous_switch_ctrl_r) begin // RULE1
      fet_nxt.chg  = !chg_block && !hold_chg_r; // RULE5
      fet_nxt.dsg  = !dsg_block && !hold_dsg_r; // RULE6
      fet_nxt.pchg = pchg_request && !chg_block && !hold_chg_r; // RULE7
      fet_nxt.pdsg = pdsg_request && !dsg_block && !hold_dsg_r; // RULE8
    end else begin
      fet_nxt = pfa_fet_s'(test_r); // RULE1
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fet_r <= '0;
    end else if (clk_en) begin
      fet_r <= fet_nxt;
    end
  end

  chk_test_mode_drive: assert property ( // RULE1
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !autonomous_switch_ctrl_r |=>
      fet_r == pfa_fet_s'($past(test_r)))
    else $error("test mode switch drive mismatch");

  chk_pin_sets_hold: assert property ( // RULE2
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && pin_lvl_r[0] |=> hold_chg_r)
    else $error("charge pin did not set hold");

  chk_disabled_silent: assert property ( // RULE3
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !prot_en_r[FLAG_W-2] |=>
      !alert_r[FLAG_W-2] && !fault_r[FLAG_W-2])
    else $error("disabled protection raised a flag");

  chk_firmware_held: assert property ( // RULE4
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !fw_eval_tick && $stable(prot_en_r) |=>
      alert_r[GRP_B_LSB +: GRP_W] == $past(alert_r[GRP_B_LSB +: GRP_W]))
    else $error("firmware group changed without tick");

  chk_charge_cut: assert property ( // RULE5
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && autonomous_switch_ctrl_r && chg_block |=> !fet_r.chg)
    else $error("charge switch on during masked fault");

  chk_discharge_cut: assert property ( // RULE6
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && autonomous_switch_ctrl_r && dsg_block |=> !fet_r.dsg)
    else $error("discharge switch on during masked fault");

  chk_precharge_cut: assert property ( // RULE7
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && autonomous_switch_ctrl_r && chg_block |=> !fet_r.pchg)
    else $error("precharge switch on during charge fault");

  chk_predischarge_cut: assert property ( // RULE8
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && autonomous_switch_ctrl_r && dsg_block |=> !fet_r.pdsg)
    else $error("predischarge on during discharge fault");

  chk_alert_same_eval: assert property ( // RULE9
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && prot_en_r[FLAG_W-1] && prot_violation[FLAG_W-1] |=>
      alert_r[FLAG_W-1])
    else $error("alert not set in the evaluation cycle");

  chk_alert_pin_any: assert property ( // RULE10
    @(posedge core_clk) disable iff (!rst_b)
    (alert_r != FLAG_RST) |-> host_alert)
    else $error("alert present but pin low");

  chk_fault_persist: assert property ( // RULE11
    @(posedge core_clk) disable iff (!rst_b)
    $rose(fault_r[FLAG_W-1]) |-> $past(due[FLAG_W-1]))
    else $error("fault raised before delay elapsed");

  chk_fault_pin_any: assert property ( // RULE12
    @(posedge core_clk) disable iff (!rst_b)
    (fault_r != FLAG_RST) |-> host_alert)
    else $error("fault present but pin low");

  chk_paused_follow: assert property ( // RULE17
    @(posedge core_clk) disable iff (!rst_b)
    clk_en |=> alert_r[PRECHARGE_TIMER_PAUSED_FLAG_BIT] == $past(precharge_timer_paused))
    else $error("timer paused alert does not follow input");

  chk_release_blocked: assert property ( // RULE18
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && hold_chg_r && chg_block |=> hold_chg_r)
    else $error("hold released while charge blocked");

  chk_reserved_zero: assert property ( // RULE19
    @(posedge core_clk) disable iff (!rst_b)
    ((alert_r & ~ALERT_VALID) == FLAG_RST) &&
    ((fault_r & ~FAULT_VALID) == FLAG_RST))
    else $error("reserved flag bit set");

  chk_alert_selfclear: assert property ( // RULE20
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !prot_violation[FLAG_W-1] |=> !alert_r[FLAG_W-1])
    else $error("alert stayed after violation cleared");

endmodule

// *** verilog/pfa_pkg.sv ***
// constants, register map and carrier types for the protection flag
// aggregator; assumes a 32-bit APB master and a single core clock
package pfa_pkg;

  localparam int FLAG_W = 24;
  localparam int GRP_W  = 8;
  localparam int NGRP   = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 6;
  localparam int FET_W  = 4;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CMP_ALERT  = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CMP_FAULT  = 6'h03;
  localparam logic [IDX_W-1:0] IDX_THM_ALERT  = 6'h04;
  localparam logic [IDX_W-1:0] IDX_THM_FAULT  = 6'h05;
  localparam logic [IDX_W-1:0] IDX_MISC_ALERT = 6'h06;
  localparam logic [IDX_W-1:0] IDX_MISC_FAULT = 6'h07;
  localparam logic [IDX_W-1:0] IDX_PROT_EN    = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CHG_MASK   = 6'h09;
  localparam logic [IDX_W-1:0] IDX_DSG_MASK   = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_DLY_A      = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_DLY_C      = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CTRL       = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 6'h0F;

  // control register fields
  localparam int CTRL_AUTO_BIT    = 0;
  localparam int CTRL_CHG_OFF_BIT = 1;
  localparam int CTRL_DSG_OFF_BIT = 2;
  localparam int CTRL_RELEASE_BIT = 3;
  localparam int CTRL_TEST_LSB    = 4;
  localparam logic CTRL_AUTO_RST  = 1'b1;

  // flag vector: group A [23:16], group B [15:8], group C [7:0]
  localparam int GRP_A_LSB = 16;
  localparam int GRP_B_LSB = 8;
  localparam int GRP_C_LSB = 0;
  localparam int PRECHARGE_TIMER_PAUSED_FLAG_BIT  = 3;
  localparam logic [FLAG_W-1:0] ALERT_VALID = 24'hFC_F7F8;
  localparam logic [FLAG_W-1:0] FAULT_VALID = 24'hFC_F7F6;
  localparam logic [FLAG_W-1:0] PRECHARGE_TIMER_PAUSED_FLAG_FLAG   = 24'h00_0008;
  localparam logic [FLAG_W-1:0] HW_GROUP    = 24'hFF_0000;
  localparam logic [FLAG_W-1:0] FLAG_RST    = 24'h00_0000;

  typedef struct packed {
    logic chg;
    logic dsg;
    logic pchg;
    logic pdsg;
  } pfa_fet_s;

  function automatic logic pfa_hit(input logic [ADDR_W-1:0] a,
                                   input logic [IDX_W-1:0]  idx);
    return a == {idx, 2'b00};
  endfunction

endpackage

// *** testbench/pfa_host_model.sv ***
// host processor model: apb master and the two switch-off pins
// assumes one core clock and a slave answering with pready
`timescale 1ns/1ps
module pfa_host_model
  import pfa_pkg::*;
(
  // clock and apb answer
  input  wire logic              core_clk,
  input  wire logic              pready,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pslverr,
  // apb request
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [DATA_W-1:0] pwdata,
  // host-forced switch-off pins
  output logic                   charge_path_off_pin,
  output logic                   discharge_path_off_pin
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    charge_path_off_pin = 1'b0;
    discharge_path_off_pin = 1'b0;
  end

  // request held until pready is seen high, only then released
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines carry the inverse so stale values never match
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // a forced pin sets a hold that keeps its switch off, even after the pin drops, until a release write
  task automatic set_pins(input logic chg, input logic dsg);
    @(posedge core_clk);
    charge_path_off_pin <= chg;
    discharge_path_off_pin <= dsg;
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the protection flag aggregator
// assumes the host model as apb master; clk_en held high except during test_freeze
`timescale 1ns/1ps
module testbench
  import pfa_pkg::*;
;
  logic              core_clk;
  logic              rst_b;
  logic              clk_en;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [FLAG_W-1:0] prot_violation;
  logic              fw_eval_tick;
  logic              precharge_timer_paused;
  logic              pchg_request;
  logic              pdsg_request;
  logic              chg_pin;
  logic              dsg_pin;
  logic              host_alert;
  pfa_fet_s          autonomous_switch_ctrl;
  int                miscompares;
  int                num_checks;

  pfa_flag_aggregator dut (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prot_violation(prot_violation),
    .fw_eval_tick(fw_eval_tick),
    .precharge_timer_paused(precharge_timer_paused),
    .pchg_request(pchg_request), .pdsg_request(pdsg_request),
    .charge_path_off_pin(chg_pin), .discharge_path_off_pin(dsg_pin),
    .host_alert(host_alert), .autonomous_switch_ctrl(autonomous_switch_ctrl));

  pfa_host_model host (.core_clk(core_clk), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .charge_path_off_pin(chg_pin), .discharge_path_off_pin(dsg_pin));

  always #20 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic fchk(input logic [3:0] x);
    chk({28'h0, autonomous_switch_ctrl}, {28'h0, x});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic              e;
    host.xfer(1'b1, {i, 2'b00}, d, q, e);
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] i,
                        input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    logic              e;
    host.xfer(1'b0, {i, 2'b00}, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic pulse_tick();
    fw_eval_tick <= 1'b1;
    @(posedge core_clk);
    fw_eval_tick <= 1'b0;
  endtask

  task automatic test_reset();
    rd_chk(IDX_CMP_ALERT, 32'h0);
    rd_chk(IDX_MISC_FAULT, 32'h0);
    rd_chk(IDX_CTRL, 32'h0000_0001);
    fchk(4'hC);
  endtask

  task automatic test_group_a();
    wr(IDX_PROT_EN, 32'h0080_0000);
    wr(IDX_CHG_MASK, 32'h0080_0000);
    wr(IDX_DLY_A, 32'h0000_0002);
    pchg_request <= 1'b1;
    wait_cyc(2);
    fchk(4'hE);
    // bit 22 violates too but is not enabled
    prot_violation <= 24'hC0_0000;
    rd_chk(IDX_CMP_FAULT, 32'h0);
    rd_chk(IDX_CMP_ALERT, 32'h0000_0080);
    wait_cyc(4);
    rd_chk(IDX_CMP_FAULT, 32'h0000_0080);
    chk({31'h0, host_alert}, 32'h1);
    fchk(4'h4);
    prot_violation <= '0;
    wait_cyc(4);
    rd_chk(IDX_CMP_ALERT, 32'h0);
    chk({31'h0, host_alert}, 32'h0);
    fchk(4'hE);
    pdsg_request <= 1'b1;
    wr(IDX_CHG_MASK, 32'h0);
    wr(IDX_DSG_MASK, 32'h0080_0000);
    prot_violation <= 24'h80_0000;
    wait_cyc(6);
    fchk(4'hA);
    prot_violation <= '0;
    wr(IDX_DSG_MASK, 32'h0);
    wait_cyc(3);
    fchk(4'hF);
  endtask

  task automatic test_firmware();
    wr(IDX_PROT_EN, 32'h00FF_FFFF);
    wr(IDX_DLY_A + 6'h01, 32'h0);
    wr(IDX_DLY_C, 32'h0);
    prot_violation <= 24'hFF_FFFF;
    precharge_timer_paused <= 1'b1;
    wait_cyc(8);
    rd_chk(IDX_THM_ALERT, 32'h0);
    pulse_tick();
    wait_cyc(4);
    rd_chk(IDX_CMP_ALERT, 32'h0000_00FC);
    rd_chk(IDX_CMP_FAULT, 32'h0000_00FC);
    rd_chk(IDX_THM_ALERT, 32'h0000_00F7);
    rd_chk(IDX_THM_FAULT, 32'h0000_00F7);
    rd_chk(IDX_MISC_ALERT, 32'h0000_00F8);
    rd_chk(IDX_MISC_FAULT, 32'h0000_00F6);
    prot_violation <= '0;
    precharge_timer_paused <= 1'b0;
    wr(IDX_THM_ALERT, 32'hFFFF_FFFF);
    wait_cyc(3);
    // firmware groups keep their last sample until the next tick
    rd_chk(IDX_THM_ALERT, 32'h0000_00F7);
    pulse_tick();
    wait_cyc(3);
    rd_chk(IDX_MISC_ALERT, 32'h0);
    rd_chk(IDX_THM_FAULT, 32'h0);
  endtask

  task automatic test_hold();
    host.set_pins(1'b1, 1'b0);
    wait_cyc(8);
    fchk(4'h5);
    wr(IDX_CTRL, 32'h0000_0009);
    wait_cyc(3);
    fchk(4'h5);
    host.set_pins(1'b0, 1'b0);
    wait_cyc(8);
    fchk(4'h5);
    wr(IDX_CTRL, 32'h0000_0009);
    wait_cyc(3);
    fchk(4'hF);
    wr(IDX_CTRL, 32'h0000_0005);
    wait_cyc(3);
    fchk(4'hA);
    wr(IDX_CTRL, 32'h0000_0009);
    wait_cyc(3);
    fchk(4'hF);
  endtask

  task automatic test_mode_and_map();
    logic [DATA_W-1:0] q;
    logic              e;
    wr(IDX_CTRL, 32'h0000_0050);
    wait_cyc(3);
    fchk(4'h5);
    wr(IDX_CTRL, 32'h0000_0001);
    wait_cyc(3);
    fchk(4'hF);
    host.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    host.xfer(1'b0, 8'h09, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
  endtask

  // a low enable freezes evaluation; the alert shows once it returns
  task automatic test_freeze();
    clk_en <= 1'b0;
    prot_violation <= 24'h80_0000;
    wait_cyc(4);
    chk({31'h0, host_alert}, 32'h0);
    clk_en <= 1'b1;
    wait_cyc(2);
    chk({31'h0, host_alert}, 32'h1);
    prot_violation <= '0;
    wait_cyc(2);
  endtask

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    prot_violation = '0;
    fw_eval_tick = 1'b0;
    precharge_timer_paused = 1'b0;
    pchg_request = 1'b0;
    pdsg_request = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    test_reset();
    test_group_a();
    test_firmware();
    test_hold();
    test_mode_and_map();
    test_freeze();
    give_verdict();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule
